// file: rtl/dc_sync_map.vh
`ifndef DC_SYNC_MAP_VH
`define DC_SYNC_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_OWNERSHIP 12'h980
`define ADDR_ACTIVATION 12'h981
`define ADDR_LEN_LO 12'h982
`define ADDR_LEN_HI 12'h983
`define ADDR_ACT_STATUS 12'h984
`define ADDR_STATUS_A 12'h98e
`define ADDR_STATUS_B 12'h98f
// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define OWN_SYNC 0
`define OWN_LATCH0 4
`define OWN_LATCH1 5
`define OWN_MASK 8'h31
`define ACT_RUN 0
`define ACT_EN_A 1
`define ACT_EN_B 2
`define ACT_AUTO 3
`define ACT_EXT 4
`define ACT_CHECK 5
`define ACT_NEAR 6
`define ACT_DEBUG 7
`define ACT_MASK 8'h7f
`define STAT_PEND_A 0
`define STAT_PEND_B 1
`define STAT_OUT 2
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define OWN_RESET 8'h00
`define ACT_RESET 8'h00
`define LEN_RESET 16'h0000
`define LEN_UNIT_NS 10
`define CLOCK_NS 100
`define NEAR_SHORT_BIT 31
`define NEAR_LONG_BIT 63
`endif

// file: rtl/dc_sync_out_control.v
`timescale 1ns/1ns
`include "dc_sync_map.vh"
module dc_sync_out_control #(
	parameter ADDR_W = 12,
	parameter TIME_W = 64
) (
	// Clock, reset, enable
	input wire clock,
	input wire rst,
	input wire ce,
	// Network side register port
	input wire [ADDR_W-1:0] net_addr,
	input wire net_wr,
	input wire net_rd,
	input wire [7:0] net_wdata,
	output reg [7:0] net_rdata,
	// Local host interface register port
	input wire [ADDR_W-1:0] local_addr,
	input wire local_wr,
	input wire local_rd,
	input wire [7:0] local_wdata,
	output reg [7:0] local_rdata,
	input wire local_ack_by_write,
	// Start time write and cycle settings
	input wire start_wr,
	input wire start_wr_local,
	input wire start_lo_only,
	input wire [TIME_W-1:0] start_data,
	input wire [31:0] cycle_time_a,
	input wire [31:0] delay_b,
	// Configuration memory load of the pulse length
	input wire cfg_load,
	input wire [15:0] cfg_pulse_len,
	// System time and its owner
	input wire [TIME_W-1:0] system_time,
	input wire systime_local_ctrl,
	// Latch interrupts and their routing
	input wire latch0_irq,
	input wire latch1_irq,
	output wire latch0_irq_net,
	output wire latch0_irq_local,
	output wire latch1_irq_net,
	output wire latch1_irq_local,
	// Sync outputs and status
	output reg sync_pulse_a,
	output reg sync_pulse_b,
	output reg event_req_a,
	output wire [TIME_W-1:0] next_a_time
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] ownership;
reg [7:0] activation;
reg [15:0] pulse_len;
reg pend_a;
reg pend_b;
reg out_of_near;
reg [TIME_W-1:0] due_a;
reg [TIME_W-1:0] due_b;
reg armed_b;
reg [31:0] elapsed_a;
reg [31:0] elapsed_b;

wire local_owns = ownership[`OWN_SYNC];
wire running = activation[`ACT_RUN];
wire ack_mode = (pulse_len == 16'h0000);
wire [31:0] len_ns = pulse_len * `LEN_UNIT_NS;
wire [7:0] own_read;
wire [7:0] act_status;

assign next_a_time = due_a;

// Latch 0 ownership forced to the local side with system time there
assign own_read = ownership | {3'h0, systime_local_ctrl, 4'h0};

assign latch0_irq_net = latch0_irq & ~own_read[`OWN_LATCH0];
assign latch0_irq_local = latch0_irq & own_read[`OWN_LATCH0];
assign latch1_irq_net = latch1_irq & ~own_read[`OWN_LATCH1];
assign latch1_irq_local = latch1_irq & own_read[`OWN_LATCH1];

assign act_status = {5'h00, out_of_near, pend_b, pend_a};

// ----------------------------------------------------------------
// Read decode, shared by both ports
// ----------------------------------------------------------------
function [7:0] read_mux;
	input [ADDR_W-1:0] a;
	begin
		case (a)
		`ADDR_OWNERSHIP: read_mux = own_read;
		// Debug bit is never stored, so it reads back zero
		`ADDR_ACTIVATION: read_mux = activation & `ACT_MASK;
		`ADDR_LEN_LO: read_mux = pulse_len[7:0];
		`ADDR_LEN_HI: read_mux = pulse_len[15:8];
		`ADDR_ACT_STATUS: read_mux = act_status;
		`ADDR_STATUS_A: read_mux = {7'h00, pend_a};
		`ADDR_STATUS_B: read_mux = {7'h00, pend_b};
		default: read_mux = 8'h00;
		endcase
	end
endfunction

// Activation writes come only from the side owning the unit
wire net_act_wr = net_wr & (net_addr == `ADDR_ACTIVATION) & ~local_owns;
wire loc_act_wr = local_wr & (local_addr == `ADDR_ACTIVATION) & local_owns;
wire act_wr = net_act_wr | loc_act_wr;
wire [7:0] act_wdata = loc_act_wr ? local_wdata : net_wdata;

// Start time obeys the same owner and only while stopped
wire start_ok = start_wr & (start_wr_local == local_owns) & ~running;

// Local acknowledge of pulse a: read or, in ack-by-write mode, write
wire loc_hit_a = (local_addr == `ADDR_STATUS_A);
wire loc_hit_b = (local_addr == `ADDR_STATUS_B);
wire ack_a_loc = loc_hit_a & (local_ack_by_write ? local_wr : local_rd);
wire ack_b_loc = loc_hit_b & (local_ack_by_write ? local_wr : local_rd);
wire ack_a = ack_a_loc | (net_rd & (net_addr == `ADDR_STATUS_A));
wire ack_b = ack_b_loc | (net_rd & (net_addr == `ADDR_STATUS_B));

// ----------------------------------------------------------------
// Start time and extension
// ----------------------------------------------------------------
reg [TIME_W-1:0] next_start;
always @* begin
	next_start = start_data;
	if (start_lo_only) begin
		if (activation[`ACT_EXT]) begin
			// Pick the upper half closest ahead of the system time
			next_start[TIME_W-1:32] = system_time[TIME_W-1:32];
			if (start_data[31:0] < system_time[31:0])
				next_start[TIME_W-1:32] =
					system_time[TIME_W-1:32] + 1'b1;
		end else begin
			next_start[TIME_W-1:32] = due_a[TIME_W-1:32];
		end
	end
end

// ----------------------------------------------------------------
// Plausibility of the start time against the near future window
// ----------------------------------------------------------------
// Auto-activation checks the start time written in the same cycle,
// before it has reached due_a
wire [TIME_W-1:0] start_seen = start_ok ? next_start : due_a;
wire [TIME_W-1:0] ahead = start_seen - system_time;
wire far_short = |ahead[TIME_W-1:`NEAR_SHORT_BIT];
wire far_long = ahead[`NEAR_LONG_BIT];
// Bit 6 clear: half the clock width; set: about 2.1 s
wire outside = activation[`ACT_NEAR] ? far_short : far_long;

wire next_run = act_wr ? act_wdata[`ACT_RUN] :
	(start_ok & activation[`ACT_AUTO]) ? 1'b1 : running;
wire rise_run = next_run & ~running;
wire fire_now = rise_run & activation[`ACT_CHECK] & outside;
wire debug = act_wr & act_wdata[`ACT_DEBUG];
// The enables written with the debug bit pick the outputs it pings
wire debug_a = debug & act_wdata[`ACT_EN_A];
wire debug_b = debug & act_wdata[`ACT_EN_B];

// ----------------------------------------------------------------
// Next activation value
// ----------------------------------------------------------------
reg [7:0] next_activation;
always @* begin
	next_activation = activation;
	// The mask drops the debug bit, so it is never stored
	if (act_wr)
		next_activation = act_wdata & `ACT_MASK;
	else if (start_ok & activation[`ACT_AUTO])
		next_activation[`ACT_RUN] = 1'b1;
end

// ----------------------------------------------------------------
// Control and status registers
// ----------------------------------------------------------------
always @(posedge clock or posedge rst) begin
	if (rst) begin
		ownership <= `OWN_RESET;
		activation <= `ACT_RESET;
		pulse_len <= `LEN_RESET;
		out_of_near <= 1'b0;
		net_rdata <= 8'h00;
		local_rdata <= 8'h00;
	end else if (ce) begin
		// Only the network side may change ownership
		if (net_wr & (net_addr == `ADDR_OWNERSHIP))
			ownership <= net_wdata & `OWN_MASK;
		activation <= next_activation;
		if (cfg_load)
			pulse_len <= cfg_pulse_len;
		if (rise_run)
			out_of_near <= outside;
		net_rdata <= net_rd ? read_mux(net_addr) : 8'h00;
		local_rdata <= local_rd ? read_mux(local_addr) : 8'h00;
	end
end

// ----------------------------------------------------------------
// Pulse timing
// ----------------------------------------------------------------
wire en_a = activation[`ACT_EN_A];
wire en_b = activation[`ACT_EN_B];
reg fire_q;
reg single_done;
wire pend_a_or_cyc = ~single_done;
wire hit_a = running & en_a & pend_a_or_cyc &
	((system_time >= due_a) | fire_q);
wire hit_b = running & en_b & armed_b & (system_time >= due_b);
// A pulse drops on the edge that completes its length, so a length
// that is not a whole number of clock periods is rounded up
wire end_a = ~ack_mode & (elapsed_a + `CLOCK_NS >= len_ns);
wire end_b = ~ack_mode & (elapsed_b + `CLOCK_NS >= len_ns);

// ----------------------------------------------------------------
// Next state of both pulse outputs
// ----------------------------------------------------------------
reg next_sync_a;
reg next_sync_b;
reg [31:0] next_elapsed_a;
reg [31:0] next_elapsed_b;

// Pulse a: set at due time, by the start check firing early, or by debug, held in ack mode
always @* begin
	next_sync_a = sync_pulse_a;
	next_elapsed_a = elapsed_a;
	if (hit_a | debug_a) begin
		next_sync_a = 1'b1;
		next_elapsed_a = 32'h0;
	end else if (sync_pulse_a) begin
		next_elapsed_a = elapsed_a + `CLOCK_NS;
		if (end_a | (ack_mode & ack_a))
			next_sync_a = 1'b0;
	end
end

// Pulse b: same timing, started from its own due time
always @* begin
	next_sync_b = sync_pulse_b;
	next_elapsed_b = elapsed_b;
	if (hit_b | debug_b) begin
		next_sync_b = 1'b1;
		next_elapsed_b = 32'h0;
	end else if (sync_pulse_b) begin
		next_elapsed_b = elapsed_b + `CLOCK_NS;
		if (end_b | (ack_mode & ack_b))
			next_sync_b = 1'b0;
	end
end

always @(posedge clock or posedge rst) begin
	if (rst) begin
		due_a <= {TIME_W{1'b0}};
		due_b <= {TIME_W{1'b0}};
		armed_b <= 1'b0;
		fire_q <= 1'b0;
		single_done <= 1'b0;
		pend_a <= 1'b0;
		pend_b <= 1'b0;
		sync_pulse_a <= 1'b0;
		sync_pulse_b <= 1'b0;
		elapsed_a <= 32'h0;
		elapsed_b <= 32'h0;
		event_req_a <= 1'b0;
	end else if (ce) begin
		if (start_ok)
			due_a <= next_start;
		else if (hit_a)
			due_a <= due_a + {{(TIME_W-32){1'b0}}, cycle_time_a};
		fire_q <= fire_now;
		if (rise_run) begin
			single_done <= 1'b0;
			pend_a <= en_a;
			pend_b <= en_b;
		end else begin
			if (hit_a)
				pend_a <= 1'b0;
			if (hit_b)
				pend_b <= 1'b0;
		end
		if (~running)
			armed_b <= 1'b0;
		else if (hit_b)
			armed_b <= 1'b0;
		if (hit_a) begin
			if (cycle_time_a == 32'h0)
				single_done <= 1'b1;
			due_b <= (fire_q ? system_time : due_a) +
				{{(TIME_W-32){1'b0}}, delay_b};
			armed_b <= 1'b1;
		end
		sync_pulse_a <= next_sync_a;
		elapsed_a <= next_elapsed_a;
		sync_pulse_b <= next_sync_b;
		elapsed_b <= next_elapsed_b;
		// A new event wins over a clear in the same cycle
		if (hit_a)
			event_req_a <= 1'b1;
		else if (ack_a_loc)
			event_req_a <= 1'b0;
	end
end

endmodule

// file: bench/dc_sync_props.sv
`timescale 1ns/1ns
module dc_sync_props #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	input wire ce,
	// Register ports
	input wire [ADDR_W-1:0] net_addr,
	input wire net_rd,
	input wire [7:0] net_rdata,
	input wire [ADDR_W-1:0] local_addr,
	input wire local_rd,
	input wire [7:0] local_rdata,
	input wire local_ack_by_write,
	// Latch routing and sync outputs
	input wire systime_local_ctrl,
	input wire latch0_irq,
	input wire latch0_irq_net,
	input wire latch0_irq_local,
	input wire sync_pulse_a,
	input wire event_req_a
);
	// ----
	// Checks
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	latch_route_a: assert property ((latch0_irq_net || latch0_irq_local)
		== latch0_irq && !(latch0_irq_net && latch0_irq_local))
		else $error("latch interrupt misrouted");
	forced_local_a: assert property (systime_local_ctrl && latch0_irq
		|-> latch0_irq_local) else $error("latch 0 not forced local");
	debug_zero_a: assert property (ce && net_rd && net_addr == 12'h981
		|=> net_rdata[7] == 1'b0) else $error("debug bit read as 1");
	own_rsvd_a: assert property (ce && local_rd && local_addr == 12'h980
		|=> (local_rdata & 8'hce) == 8'h00) else $error("reserved bits set");
	stat_rsvd_a: assert property (ce && net_rd && net_addr == 12'h984
		|=> net_rdata[7:3] == 5'h00) else $error("status bits 7:3 set");
	pend_rsvd_a: assert property (ce && local_rd && local_addr == 12'h98e
		|=> local_rdata[7:1] == 7'h00) else $error("status bits 7:1 set");
	// A pulse landing on the same edge may set the request again
	read_clear_a: assert property (ce && local_rd && local_addr == 12'h98e
		&& !local_ack_by_write |=> !event_req_a || $rose(sync_pulse_a))
		else $error("event request not cleared by read");
	event_cause_a: assert property ($rose(event_req_a)
		|-> $rose(sync_pulse_a)) else $error("event request without pulse");
endmodule

// file: bench/sys_time_model.sv
`timescale 1ns/1ns
module sys_time_model (
	// Clock and reset
	input wire clock,
	input wire rst,
	// Time seen by the unit
	output reg [63:0] system_time
);
	// One clock period per cycle; drift control is not modelled
	always @(posedge clock or posedge rst) begin
		if (rst)
			system_time <= 64'h1000;
		else
			system_time <= system_time + 64'd100;
	end
endmodule

// file: bench/test_dc_sync_out_control.sv
`timescale 1ns/1ns
`include "dc_sync_map.vh"
module test_dc_sync_out_control;
	reg clock, rst, net_wr, net_rd, local_wr, local_rd, start_wr;
	reg [11:0] net_addr, local_addr;
	reg [7:0] net_wdata, local_wdata, rv;
	wire [7:0] net_rdata, local_rdata;
	reg cfg_load, systime_local_ctrl, latch0_irq, latch1_irq, start_wr_local;
	reg [63:0] start_data, exp_t;
	reg ce, local_ack_by_write, start_lo_only;
	wire [63:0] next_a_time;
	reg [15:0] cfg_pulse_len;
	wire [63:0] system_time;
	wire latch0_irq_net, latch0_irq_local, latch1_irq_net, latch1_irq_local;
	wire sync_pulse_a, sync_pulse_b, event_req_a;
	integer bad_count, samples_checked, cycles, i;
	sys_time_model time_src (.clock, .rst, .system_time);
	dc_sync_out_control uut (.clock, .rst, .ce, .net_addr, .net_wr,
		.net_rd, .net_wdata, .net_rdata, .local_addr, .local_wr, .local_rd,
		.local_wdata, .local_rdata, .local_ack_by_write, .start_wr,
		.start_wr_local, .start_lo_only, .start_data,
		.cycle_time_a(32'h0), .delay_b(32'h0), .cfg_load, .cfg_pulse_len,
		.system_time, .systime_local_ctrl, .latch0_irq, .latch1_irq,
		.latch0_irq_net, .latch0_irq_local, .latch1_irq_net,
		.latch1_irq_local, .sync_pulse_a, .sync_pulse_b, .event_req_a,
		.next_a_time);
	// ----
	// Access tasks
	// ----
	task chk(input [15:0] got, input [15:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input loc, input [11:0] a, input [7:0] d);
		@(negedge clock);
		if (loc) {local_wr, local_addr, local_wdata} = {1'b1, a, d};
		else {net_wr, net_addr, net_wdata} = {1'b1, a, d};
		@(negedge clock);
		{net_wr, local_wr} = 2'b00;
	endtask
	task rd(input loc, input [11:0] a);
		@(negedge clock);
		if (loc) {local_rd, local_addr} = {1'b1, a};
		else {net_rd, net_addr} = {1'b1, a};
		@(negedge clock);
		{net_rd, local_rd} = 2'b00;
		rv = loc ? local_rdata : net_rdata;
	endtask
	task summarize;
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Far above the few hundred cycles the sequence needs
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			bad_count = bad_count + 1;
			summarize;
		end
	end
	// ----
	// Sequence
	// ----
	initial begin
		{rst, net_wr, net_rd, local_wr, local_rd, start_wr} = 6'h20;
		{net_addr, local_addr, net_wdata, local_wdata} = 40'h0;
		{cfg_load, systime_local_ctrl, latch0_irq, latch1_irq} = 4'h0;
		{start_wr_local, start_data, cfg_pulse_len} = 81'h0;
		{ce, local_ack_by_write, start_lo_only} = 3'b100;
		bad_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (12) @(posedge clock);
		@(negedge clock) rst = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			rd(i[0], 12'h981 + i[11:0]);
			chk(rv, 8'h00);
		end
		wr(1, `ADDR_OWNERSHIP, 8'h31);
		rd(0, `ADDR_OWNERSHIP);
		chk(rv, 8'h00);
		wr(0, `ADDR_OWNERSHIP, 8'hff);
		rd(1, `ADDR_OWNERSHIP);
		chk(rv, 8'h31);
		// A write while the clock enable is low must leave no trace
		@(negedge clock) ce = 1'b0;
		wr(0, `ADDR_OWNERSHIP, 8'h00);
		@(negedge clock) ce = 1'b1;
		rd(1, `ADDR_OWNERSHIP);
		chk(rv, 8'h31);
		{latch0_irq, latch1_irq} = 2'b11;
		#1 chk({latch0_irq_net, latch0_irq_local, latch1_irq_net, latch1_irq_local}, 4'h5);
		wr(0, `ADDR_OWNERSHIP, 8'h01);
		systime_local_ctrl = 1'b1;
		rd(0, `ADDR_OWNERSHIP);
		chk(rv, 8'h11);
		chk({latch0_irq_net, latch0_irq_local, latch1_irq_net, latch1_irq_local}, 4'h6);
		{systime_local_ctrl, latch0_irq, latch1_irq, start_wr_local} = 4'h1;
		wr(0, `ADDR_ACTIVATION, 8'h03);
		rd(1, `ADDR_ACTIVATION);
		chk(rv, 8'h00);
		@(negedge clock) {cfg_load, cfg_pulse_len} = {1'b1, 16'h0105};
		@(negedge clock) cfg_load = 1'b0;
		wr(0, `ADDR_LEN_LO, 8'hff);
		rd(0, `ADDR_LEN_LO);
		chk(rv, 8'h05);
		rd(1, `ADDR_LEN_HI);
		chk(rv, 8'h01);
		wr(1, `ADDR_ACTIVATION, 8'h0a);
		@(negedge clock) {start_wr, start_data} = {1'b1, system_time + 64'd3000};
		@(negedge clock) start_wr = 1'b0;
		rd(1, `ADDR_ACTIVATION);
		chk(rv, 8'h0b);
		rd(0, `ADDR_ACT_STATUS);
		chk(rv, 8'h01);
		for (i = 0; i < 60 && sync_pulse_a !== 1'b1; i = i + 1) @(negedge clock);
		chk({sync_pulse_a, event_req_a}, 2'b11);
		// 0x105 units of 10 ns round up to 27 clock periods
		for (i = 0; i < 40 && sync_pulse_a === 1'b1; i = i + 1) @(negedge clock);
		chk(i[15:0], 16'd27);
		for (i = 0; i < 40 && sync_pulse_a !== 1'b1; i = i + 1) @(negedge clock);
		chk(i[15:0], 16'd40);
		rd(1, `ADDR_STATUS_A);
		chk({rv, 7'h0, event_req_a}, 16'h0000);
		wr(1, `ADDR_ACTIVATION, 8'h85);
		for (i = 0; i < 5 && sync_pulse_b !== 1'b1; i = i + 1) @(negedge clock);
		chk({sync_pulse_a, sync_pulse_b}, 2'b01);
		rd(1, `ADDR_ACTIVATION);
		chk(rv, 8'h05);
		wr(1, `ADDR_ACTIVATION, 8'h00);
		wr(1, `ADDR_ACTIVATION, 8'h10);
		@(negedge clock) begin
			exp_t = {32'h0, system_time[31:0] + 32'd5000};
			{start_wr, start_lo_only} = 2'b11;
			start_data = {32'hffffffff, exp_t[31:0]};
		end
		@(negedge clock) {start_wr, start_lo_only} = 2'b00;
		@(negedge clock) chk(next_a_time[63:48], exp_t[63:48]);
		chk(next_a_time[15:0], exp_t[15:0]);
		@(negedge clock) {start_wr, start_data} = {1'b1, 64'h0};
		@(negedge clock) start_wr = 1'b0;
		wr(1, `ADDR_ACTIVATION, 8'h23);
		for (i = 0; i < 4 && sync_pulse_a !== 1'b1; i = i + 1) @(negedge clock);
		chk(sync_pulse_a, 1'b1);
		rd(0, `ADDR_ACT_STATUS);
		chk(rv[2], 1'b1);
		chk(event_req_a, 1'b1);
		local_ack_by_write = 1'b1;
		rd(1, `ADDR_STATUS_A);
		chk(event_req_a, 1'b1);
		wr(1, `ADDR_STATUS_A, 8'h00);
		chk(event_req_a, 1'b0);
		@(negedge clock) {cfg_load, cfg_pulse_len} = {1'b1, 16'h0000};
		@(negedge clock) cfg_load = 1'b0;
		wr(1, `ADDR_ACTIVATION, 8'h83);
		repeat (30) @(negedge clock);
		chk(sync_pulse_a, 1'b1);
		rd(0, `ADDR_STATUS_A);
		chk(sync_pulse_a, 1'b0);
		summarize;
	end
endmodule
bind dc_sync_out_control dc_sync_props #(.ADDR_W(ADDR_W)) props (.clock,
	.rst, .ce, .net_addr, .net_rd, .net_rdata, .local_addr, .local_rd,
	.local_rdata, .local_ack_by_write, .systime_local_ctrl, .latch0_irq,
	.latch0_irq_net, .latch0_irq_local, .sync_pulse_a, .event_req_a);
